// ### hw/ddt_defs.svh
// Purpose: numeric constants of the termination controller
// Assumes: included by the package and every design module
// Notes: definitions only
`ifndef DDT_DEFS_SVH
`define DDT_DEFS_SVH

// Synchronised pin vector layout
`define DDT_PIN_W 25
`define DDT_PIN_CK 0
`define DDT_PIN_ODT 1
`define DDT_PIN_CKE 2
`define DDT_PIN_CSN 3
`define DDT_PIN_RASN 4
`define DDT_PIN_CASN 5
`define DDT_PIN_WEN 6
`define DDT_PIN_BA_LO 7
`define DDT_PIN_A_LO 10

// APB register offsets
`define DDT_OFS_CFG 8'h00
`define DDT_OFS_STATUS 8'h04
`define DDT_OFS_MR0 8'h08
`define DDT_OFS_MR1 8'h0C
`define DDT_OFS_MR2 8'h10

// CFG fields and reset values
`define DDT_CFG_TCPDED_LO 0
`define DDT_CFG_TRFC_LO 8
`define DDT_CFG_TCPDED_RST 8'h01
`define DDT_CFG_TRFC_RST 16'h00A0
`define DDT_MR_RST 16'h0000

// Mode register selects and field positions
`define DDT_BA_MR0 3'h0
`define DDT_BA_MR1 3'h1
`define DDT_BA_MR2 3'h2
`define DDT_MR0_BL_LO 0
`define DDT_MR0_CL_A2 2
`define DDT_MR0_CL_LO 4
`define DDT_MR0_PPD 12
`define DDT_MR1_NOM_A2 2
`define DDT_MR1_AL_LO 3
`define DDT_MR1_NOM_A6 6
`define DDT_MR1_NOM_A9 9
`define DDT_MR2_CWL_LO 3
`define DDT_MR2_WR_A9 9
`define DDT_MR2_WR_A10 10
`define DDT_WR_BL_BIT 12

// Latency arithmetic, in CK cycles
`define DDT_CWL_BASE 6'd5
`define DDT_CL_BASE_LO 6'd4
`define DDT_CL_BASE_HI 6'd12
`define DDT_ODTL_SUB 6'd2
`define DDT_CWN4_ADD 6'd4
`define DDT_CWN8_ADD 6'd6

// Asynchronous response window, in ps
`define DDT_TCK_PS 10000
`define DDT_TAONPD_MIN_PS 2000
`define DDT_TAONPD_MAX_PS 8500

`endif

// ### hw/ddt_pkg.sv
// Purpose: shared types of the termination controller
// Assumes: ddt_defs.svh gives the widths
// Notes: one packed state struct per module
`include "ddt_defs.svh"
package ddt_pkg;
    typedef enum logic [1:0] {
        DDT_PD_ACT = 2'b00,
        DDT_PD_TRANS = 2'b01,
        DDT_PD_ASYNC = 2'b11
    } ddt_pd_t;

    typedef enum logic [1:0] {
        DDT_BL_FIX8 = 2'b00,
        DDT_BL_OTF = 2'b01,
        DDT_BL_FIX4 = 2'b10
    } ddt_bl_t;

    typedef logic [`DDT_PIN_W-1:0] ddt_pins_t;

    typedef struct packed {
        ddt_pins_t s1;
        ddt_pins_t s2;
    } ddt_sync_st_t;

    typedef struct packed {
        logic [7:0] tcpded;
        logic [15:0] trfc;
        logic [31:0] rdata;
    } ddt_apb_st_t;

    typedef struct packed {
        logic ck_d;
        logic cke_d;
        logic [15:0] mr0;
        logic [15:0] mr1;
        logic [15:0] mr2;
        logic [31:0] odt_h;
        logic [31:0] wr_h;
        logic [31:0] bc4_h;
        logic [31:0] fl_h;
        logic [31:0] tr_h;
        ddt_pd_t pd;
        logic [15:0] win_cnt;
        logic [15:0] rfc_cnt;
        logic pend_off;
        logic pend_wr;
        logic pend_nom;
        logic [3:0] apipe;
        logic rtt_on;
        logic rtt_wr_sel;
        logic rtt_unc;
        logic [2:0] rtt_code;
    } ddt_core_st_t;
endpackage

// ### hw/ddt_sync.sv
// Purpose: two-stage synchroniser for all DRAM-side pins
// Assumes: pins change well away from pclk edges only by chance
// Notes: first stage feeds only the second stage
`include "ddt_defs.svh"
module ddt_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins in and synchronised copy out
    input wire ddt_pkg::ddt_pins_t pins_async,
    output ddt_pkg::ddt_pins_t pins_sync
);
    ddt_pkg::ddt_sync_st_t q_ff;
    ddt_pkg::ddt_sync_st_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.s1 = pins_async;
        nxt_q.s2 = q_ff.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign pins_sync = q_ff.s2;
endmodule // ddt_sync

// ### hw/ddt_apb.sv
// Purpose: APB slave with config and read-back registers
// Assumes: zero wait states, read data latched in setup
// Notes: unmapped access answers pslverr
`include "ddt_defs.svh"
module ddt_apb (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block side
    input wire logic [31:0] status,
    input wire logic [15:0] mr0,
    input wire logic [15:0] mr1,
    input wire logic [15:0] mr2,
    output logic [7:0] cfg_tcpded,
    output logic [15:0] cfg_trfc
);
    ddt_pkg::ddt_apb_st_t q_ff;
    ddt_pkg::ddt_apb_st_t nxt_q;
    logic hit;
    logic [31:0] rd_mux;

    always_comb begin
        nxt_q = q_ff;
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `DDT_OFS_CFG: rd_mux = {8'h00, q_ff.trfc, q_ff.tcpded};
            `DDT_OFS_STATUS: rd_mux = status;
            `DDT_OFS_MR0: rd_mux = {16'h0000, mr0};
            `DDT_OFS_MR1: rd_mux = {16'h0000, mr1};
            `DDT_OFS_MR2: rd_mux = {16'h0000, mr2};
            default: hit = 1'b0;
        endcase
        // Latch in setup so prdata is a flop output at the access edge
        if (psel && !penable && !pwrite) begin
            nxt_q.rdata = rd_mux;
        end
        if (psel && penable && pwrite && paddr == `DDT_OFS_CFG) begin
            nxt_q.tcpded = pwdata[`DDT_CFG_TCPDED_LO +: 8];
            nxt_q.trfc = pwdata[`DDT_CFG_TRFC_LO +: 16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= {`DDT_CFG_TCPDED_RST, `DDT_CFG_TRFC_RST, 32'h0000_0000};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign prdata = q_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign cfg_tcpded = q_ff.tcpded;
    assign cfg_trfc = q_ff.trfc;
endmodule // ddt_apb

// ### hw/ddt_core.sv
// Purpose: on-die termination control with dynamic write strength
// Assumes: CK, ODT, CKE and command pins are asynchronous to pclk
// Notes: CK edges are found by oversampling at pclk
//
// Chosen here: the APB register port and the address map.
`include "ddt_defs.svh"

// What this block does
// - Either write-termination bit enables dynamic switching
// - Nominal value from MR1 A9, A6, A2
// - Write value from MR2 A10, A9
// - No write: nominal strength, ODT-pin timed
// - On/off after WL minus two cycles
// - Write selects write strength after WL-2
// - Back to nominal at off+4 or off+6
// - Off and strength changes half cycle late
// - Frozen DLL power-down uses asynchronous response
// - Asynchronous path ignores additive latency
// - Asynchronous change 3 to 4 pclk after the pin, not within 2 to 8.5 ns
// - ODT receiver stays live in power-down
// - Entry transition period when DLL frozen
// - Period from WL-1 before to tCPDED end
// - Refresh in progress may extend the period
// - Start excluded, end point included
// - Period response between async and sync timings
module ddt_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // DRAM pins from the controller
    input wire logic ck,
    input wire logic odt,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [14:0] a,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Termination control
    output logic rtt_on,
    output logic rtt_wr_sel,
    output logic [2:0] rtt_code,
    output logic async_mode,
    output logic trans_window,
    output logic rtt_uncertain
);
    // async delay from the 2 ns / 8.5 ns bounds
    localparam int ASYNC_MIN_CYC_RAW =
        (`DDT_TAONPD_MIN_PS + `DDT_TCK_PS - 1) / `DDT_TCK_PS;
    localparam int ASYNC_MAX_CYC_RAW = `DDT_TAONPD_MAX_PS / `DDT_TCK_PS;
    localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
    localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
    localparam int ASYNC_CYC = (ASYNC_MIN_CYC > ASYNC_MAX_CYC) ? ASYNC_MAX_CYC
                                                               : ASYNC_MIN_CYC;

    ddt_pkg::ddt_core_st_t q_ff;
    ddt_pkg::ddt_core_st_t nxt_q;
    ddt_pkg::ddt_pins_t pins_sync;
    logic [31:0] status;
    logic [7:0] cfg_tcpded;
    logic [15:0] cfg_trfc;

    // Decoded synchronised pins
    logic s_ck;
    logic s_odt;
    logic s_cke;
    logic s_csn;
    logic s_rasn;
    logic s_casn;
    logic s_wen;
    logic [2:0] s_ba;
    logic [14:0] s_a;

    // Working terms
    logic ck_rise;
    logic ck_fall;
    logic cmd_ok;
    logic cmd_wr;
    logic cmd_mrs;
    logic cmd_ref;
    logic cke_first_low;
    logic dyn_en;
    logic wr_bc4;
    logic [5:0] cl;
    logic [5:0] al;
    logic [5:0] cwl;
    logic [5:0] lat;
    logic [5:0] lat4;
    logic [5:0] lat8;
    logic due_on;
    logic wr_start;
    logic wr_end;
    logic in_win;
    logic [15:0] win_len;

    ddt_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pins_async({a, ba, we_n, cas_n, ras_n, cs_n, cke, odt, ck}),
        .pins_sync(pins_sync)
    );

    ddt_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .mr0(q_ff.mr0),
        .mr1(q_ff.mr1),
        .mr2(q_ff.mr2),
        .cfg_tcpded(cfg_tcpded),
        .cfg_trfc(cfg_trfc)
    );

    assign s_ck = pins_sync[`DDT_PIN_CK];
    // ODT sampled in every power state
    assign s_odt = pins_sync[`DDT_PIN_ODT];
    assign s_cke = pins_sync[`DDT_PIN_CKE];
    assign s_csn = pins_sync[`DDT_PIN_CSN];
    assign s_rasn = pins_sync[`DDT_PIN_RASN];
    assign s_casn = pins_sync[`DDT_PIN_CASN];
    assign s_wen = pins_sync[`DDT_PIN_WEN];
    assign s_ba = pins_sync[`DDT_PIN_BA_LO +: 3];
    assign s_a = pins_sync[`DDT_PIN_A_LO +: 15];

    always_comb begin
        nxt_q = q_ff;
        ck_rise = s_ck & ~q_ff.ck_d;
        ck_fall = ~s_ck & q_ff.ck_d;
        nxt_q.ck_d = s_ck;
        // Commands only count while CKE stays high
        cmd_ok = s_cke & q_ff.cke_d & ~s_csn;
        cmd_wr = cmd_ok & s_rasn & ~s_casn & ~s_wen;
        cmd_mrs = cmd_ok & ~s_rasn & ~s_casn & ~s_wen;
        cmd_ref = cmd_ok & ~s_rasn & ~s_casn & s_wen;
        cke_first_low = q_ff.cke_d & ~s_cke;
        dyn_en = q_ff.mr2[`DDT_MR2_WR_A9] | q_ff.mr2[`DDT_MR2_WR_A10];
        unique case (ddt_pkg::ddt_bl_t'(q_ff.mr0[`DDT_MR0_BL_LO +: 2]))
            ddt_pkg::DDT_BL_FIX4: wr_bc4 = 1'b1;
            ddt_pkg::DDT_BL_OTF: wr_bc4 = ~s_a[`DDT_WR_BL_BIT];
            ddt_pkg::DDT_BL_FIX8: wr_bc4 = 1'b0;
            default: wr_bc4 = 1'b0;
        endcase
        if (q_ff.mr0[`DDT_MR0_CL_A2]) begin
            cl = {3'b000, q_ff.mr0[`DDT_MR0_CL_LO +: 3]} + `DDT_CL_BASE_HI;
        end else begin
            cl = {3'b000, q_ff.mr0[`DDT_MR0_CL_LO +: 3]} + `DDT_CL_BASE_LO;
        end
        unique case (q_ff.mr1[`DDT_MR1_AL_LO +: 2])
            2'b01: al = cl - 6'd1;
            2'b10: al = cl - 6'd2;
            default: al = 6'd0;
        endcase
        cwl = {3'b000, q_ff.mr2[`DDT_MR2_CWL_LO +: 3]} + `DDT_CWL_BASE;
        // ODTLon = ODTLoff = WL - 2 with WL = CWL + AL
        lat = cwl + al - `DDT_ODTL_SUB;
        lat4 = lat + `DDT_CWN4_ADD;
        lat8 = lat + `DDT_CWN8_ADD;
        due_on = 1'b0;
        wr_start = 1'b0;
        wr_end = 1'b0;
        in_win = 1'b0;
        win_len = 16'h0000;
        // async path taps the pin with no additive latency
        nxt_q.apipe = {q_ff.apipe[2:0], s_odt};

        if (ck_rise) begin
            nxt_q.cke_d = s_cke;
            nxt_q.odt_h = {q_ff.odt_h[30:0], s_odt};
            nxt_q.wr_h = {q_ff.wr_h[30:0], cmd_wr};
            nxt_q.bc4_h = {q_ff.bc4_h[30:0], wr_bc4};
            nxt_q.fl_h = {q_ff.fl_h[30:0], cke_first_low};
            nxt_q.tr_h = {q_ff.tr_h[30:0], q_ff.pd == ddt_pkg::DDT_PD_TRANS};
            if (cmd_mrs) begin
                unique case (s_ba)
                    `DDT_BA_MR0: nxt_q.mr0 = {1'b0, s_a};
                    `DDT_BA_MR1: nxt_q.mr1 = {1'b0, s_a};
                    `DDT_BA_MR2: nxt_q.mr2 = {1'b0, s_a};
                    default: nxt_q.mr0 = q_ff.mr0;
                endcase
            end
            // refresh still running extends the period
            if (cmd_ref) begin
                nxt_q.rfc_cnt = cfg_trfc;
            end else if (q_ff.rfc_cnt != 16'h0000) begin
                nxt_q.rfc_cnt = q_ff.rfc_cnt - 16'h0001;
            end
            due_on = nxt_q.odt_h[lat[4:0]];
            wr_start = nxt_q.wr_h[lat[4:0]] & dyn_en;
            // return per burst size of that write
            wr_end = (nxt_q.wr_h[lat4[4:0]] & nxt_q.bc4_h[lat4[4:0]])
                   | (nxt_q.wr_h[lat8[4:0]] & ~nxt_q.bc4_h[lat8[4:0]]);
            // sample WL-1 before CKE low excluded, later ones in
            for (int i = 0; i < 32; i++) begin
                if (i <= int'(lat) && nxt_q.fl_h[i]) begin
                    in_win = 1'b1;
                end
            end
            // flag responses that may take either timing
            nxt_q.rtt_unc = in_win | nxt_q.tr_h[lat[4:0]];
            if (q_ff.pd != ddt_pkg::DDT_PD_ASYNC) begin
                // on at ODTLon edge, off deferred
                if (due_on) begin
                    nxt_q.rtt_on = 1'b1;
                    nxt_q.pend_off = 1'b0;
                end else begin
                    nxt_q.pend_off = q_ff.rtt_on;
                end
                nxt_q.pend_wr = wr_start;
                nxt_q.pend_nom = wr_end;
            end
            unique case (q_ff.pd)
                ddt_pkg::DDT_PD_ACT: begin
                    // only with DLL frozen in power-down
                    if (cke_first_low && !q_ff.mr0[`DDT_MR0_PPD]) begin
                        // tCPDED counted from the CKE-low cycle
                        win_len = {8'h00, cfg_tcpded};
                        if (q_ff.rfc_cnt > win_len) begin
                            win_len = q_ff.rfc_cnt;
                        end
                        nxt_q.win_cnt = win_len;
                        nxt_q.pd = ddt_pkg::DDT_PD_TRANS;
                    end
                end
                ddt_pkg::DDT_PD_TRANS: begin
                    if (s_cke) begin
                        nxt_q.pd = ddt_pkg::DDT_PD_ACT;
                    end else if (q_ff.win_cnt <= 16'h0001) begin
                        // end point stays inside the period
                        nxt_q.pd = ddt_pkg::DDT_PD_ASYNC;
                        nxt_q.win_cnt = 16'h0000;
                    end else begin
                        nxt_q.win_cnt = q_ff.win_cnt - 16'h0001;
                    end
                end
                ddt_pkg::DDT_PD_ASYNC: begin
                    if (s_cke) begin
                        nxt_q.pd = ddt_pkg::DDT_PD_ACT;
                    end
                end
                default: nxt_q.pd = ddt_pkg::DDT_PD_ACT;
            endcase
        end

        // off and strength change at the following CK fall
        if (ck_fall) begin
            if (q_ff.pend_off) begin
                nxt_q.rtt_on = 1'b0;
            end
            // Back-to-back writes: the new write wins over the old end
            if (q_ff.pend_wr) begin
                nxt_q.rtt_wr_sel = 1'b1;
            end else if (q_ff.pend_nom) begin
                nxt_q.rtt_wr_sel = 1'b0;
            end
            nxt_q.pend_off = 1'b0;
            nxt_q.pend_wr = 1'b0;
            nxt_q.pend_nom = 1'b0;
        end

        if (q_ff.pd == ddt_pkg::DDT_PD_ASYNC) begin
            // pin to termination in 3 to 4 pclk, not within the 2 ns / 8.5 ns bounds
            nxt_q.rtt_on = q_ff.apipe[ASYNC_CYC-1];
            nxt_q.rtt_wr_sel = 1'b0;
            nxt_q.pend_off = 1'b0;
            nxt_q.pend_wr = 1'b0;
            nxt_q.pend_nom = 1'b0;
        end
        if (!dyn_en) begin
            nxt_q.rtt_wr_sel = 1'b0;
        end

        if (nxt_q.rtt_wr_sel) begin
            nxt_q.rtt_code = {1'b0, nxt_q.mr2[`DDT_MR2_WR_A10], nxt_q.mr2[`DDT_MR2_WR_A9]};
        end else begin
            nxt_q.rtt_code = {nxt_q.mr1[`DDT_MR1_NOM_A9], nxt_q.mr1[`DDT_MR1_NOM_A6],
                              nxt_q.mr1[`DDT_MR1_NOM_A2]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '{
                ck_d: 1'b0,
                cke_d: 1'b0,
                mr0: `DDT_MR_RST,
                mr1: `DDT_MR_RST,
                mr2: `DDT_MR_RST,
                odt_h: 32'h0000_0000,
                wr_h: 32'h0000_0000,
                bc4_h: 32'h0000_0000,
                fl_h: 32'h0000_0000,
                tr_h: 32'h0000_0000,
                pd: ddt_pkg::DDT_PD_ACT,
                win_cnt: 16'h0000,
                rfc_cnt: 16'h0000,
                pend_off: 1'b0,
                pend_wr: 1'b0,
                pend_nom: 1'b0,
                apipe: 4'h0,
                rtt_on: 1'b0,
                rtt_wr_sel: 1'b0,
                rtt_unc: 1'b0,
                rtt_code: 3'h0
            };
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Status word: latency, state and live termination flags
    assign status = {18'h0_0000, lat, q_ff.pd, q_ff.rtt_unc,
                     q_ff.pd == ddt_pkg::DDT_PD_TRANS,
                     q_ff.pd == ddt_pkg::DDT_PD_ASYNC,
                     q_ff.mr2[`DDT_MR2_WR_A9] | q_ff.mr2[`DDT_MR2_WR_A10],
                     q_ff.rtt_wr_sel, q_ff.rtt_on};

    assign rtt_on = q_ff.rtt_on;
    assign rtt_wr_sel = q_ff.rtt_wr_sel;
    assign rtt_code = q_ff.rtt_code;
    assign async_mode = q_ff.pd == ddt_pkg::DDT_PD_ASYNC;
    assign trans_window = q_ff.pd == ddt_pkg::DDT_PD_TRANS;
    assign rtt_uncertain = q_ff.rtt_unc;
endmodule // ddt_core

// ### tb/ddt_core_asserts.sv
// Purpose: port checks of the termination controller
// Assumes: one pclk domain
// Notes: bound into ddt_core
module ddt_core_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic odt,
    input wire logic cke,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rtt_on,
    input wire logic rtt_wr_sel,
    input wire logic [2:0] rtt_code,
    input wire logic async_mode,
    input wire logic trans_window
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_apb_ready: assert property (pready)
        else $error("pready low");
    a_bad_addr: assert property (psel && penable |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
        else $error("pslverr wrong");
    a_read_hold: assert property (psel && penable |=> $stable(prdata))
        else $error("prdata moved");
    a_wr_code: assert property (rtt_wr_sel |->
        rtt_code[2] == 1'b0 && rtt_code[1:0] != 2'b00)
        else $error("write code wrong");
    // Sync latency is at least three CK cycles, far above eight pclk
    a_sync_late: assert property (
        $rose(odt) && !rtt_on && !async_mode && !trans_window |=> !rtt_on [*8])
        else $error("sync turn-on early");
    a_async_on: assert property ($rose(odt) && async_mode && !rtt_on |=>
        !rtt_on ##[1:5] (rtt_on || !async_mode))
        else $error("async turn-on timing");
    a_async_off: assert property ($fell(odt) && async_mode && rtt_on |=>
        rtt_on ##[1:5] (!rtt_on || !async_mode))
        else $error("async turn-off timing");
    a_mode_excl: assert property (!(async_mode && trans_window))
        else $error("window and async together");
    a_window_end: assert property ($fell(trans_window) && !cke |-> async_mode)
        else $error("no async after window");
endmodule // ddt_core_asserts

bind ddt_core ddt_core_asserts i_ddt_core_asserts (.pclk, .presetn, .odt, .cke, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .rtt_on, .rtt_wr_sel, .rtt_code,
    .async_mode, .trans_window);

// ### tb/ddt_ctrl_model.sv
// Purpose: DDR3 controller stand-in on the DRAM pins
// Assumes: one drive call per CK cycle, after the CK fall
// Notes: CK runs free; address lines toggle on idle cycles
module ddt_ctrl_model (
    // Clock
    input wire logic pclk,
    // DRAM pins
    output logic ck,
    output logic odt,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [14:0] a
);
    timeunit 1ns;
    timeprecision 100ps;
    // Offset keeps CK edges clear of pclk edges
    initial begin
        {odt, cke, cs_n, ras_n, cas_n, we_n, ba, a} = {2'b00, 4'hF, 3'h0, 15'h0000};
        ck = 1'b0;
        #3;
        forever #40 ck = ~ck;
    end
    task automatic drive(input logic o, k, input logic [1:0] c, input logic [2:0] b,
                         input logic [14:0] ad);
        @(posedge pclk);
        odt <= o;
        cke <= k;
        {cs_n, ras_n, cas_n, we_n} <= c == 2'd1 ? 4'h4 : c == 2'd2 ? 4'h0
                                    : c == 2'd3 ? 4'h1 : 4'hF;
        ba <= c == 2'd0 ? ~ba : b;
        a <= c == 2'd0 ? ~a : ad;
    endtask
endmodule // ddt_ctrl_model

// ### tb/test_ddt_core.sv
// Purpose: self-checking bench of the termination controller
// Assumes: partner model makes CK and the DRAM pins
// Notes: outputs sampled at CK edges, clear of pclk edges
module test_ddt_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, ck, odt, cke, cs_n, ras_n, cas_n, we_n;
    logic rtt_on, rtt_wr_sel, async_mode, trans_window, rtt_uncertain;
    logic [2:0] ba, rtt_code;
    logic [14:0] a;
    int failures = 0;
    int num_checks = 0;
    int l, b, h, wc, nom;
    always #5 pclk = ~pclk;
    ddt_ctrl_model i_ddt_ctrl_model (.pclk, .ck, .odt, .cke, .cs_n, .ras_n, .cas_n, .we_n,
        .ba, .a);
    ddt_core i_ddt_core (.pclk, .presetn, .ck, .odt, .cke, .cs_n, .ras_n, .cas_n, .we_n,
        .ba, .a, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rtt_on, .rtt_wr_sel, .rtt_code, .async_mode, .trans_window, .rtt_uncertain);
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic cyc(input logic o, k, input logic [1:0] c, input logic [2:0] bk,
                       input logic [14:0] ad);
        if (ck === 1'b1) @(negedge ck);
        i_ddt_ctrl_model.drive(o, k, c, bk, ad);
        @(posedge ck);
    endtask
    // Half-step t: even at a CK rise, odd at the fall after it
    function automatic logic [4:0] exp_dyn(int t);
        logic on;
        logic wr;
        on = t >= 2 * l + 1 && t <= 2 * (h + l) + 1;
        wr = wc != 0 && t >= 2 * l + 2 && t <= 2 * (l + b) + 1;
        return {on, wr, wr ? {1'b0, 2'(wc)} : 3'(nom)};
    endfunction
    initial begin
        logic [31:0] r;
        logic e;
        int cwl, al, bm, b8, tc, tr, w, n;
        void'($urandom(32'hAC2E2798));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h00000000, r, e);
        chk("cfg reset", r, 32'h0000A001);
        apb(1'b0, 8'h14, 32'h00000000, r, e);
        chk("unmapped err", 32'(e), 32'h00000001);
        repeat (10) begin
            // Idle rises age out ODT samples left by the last pass
            repeat (3) cyc(1'b0, 1'b1, 2'd0, 3'h0, 15'h0000);
            cwl = $urandom_range(5);
            al = $urandom_range(2);
            bm = $urandom_range(2);
            b8 = bm == 0 || (bm == 1 && $urandom_range(1) == 1);
            wc = $urandom_range(3);
            nom = $urandom_range(7);
            l = cwl + 3 + (al == 1 ? 3 : al);
            b = b8 ? 6 : 4;
            h = b + $urandom_range(3);
            cyc(1'b0, 1'b1, 2'd2, 3'h0, 15'(bm));
            cyc(1'b0, 1'b1, 2'd2, 3'h1, 15'((nom[2] << 9) | (nom[1] << 6) | (nom[0] << 2) | (al << 3)));
            cyc(1'b0, 1'b1, 2'd2, 3'h2, 15'((wc << 9) | (cwl << 3)));
            // MRS is acted on 3 pclk after the CK rise
            @(negedge ck);
            apb(1'b0, 8'h04, 32'h00000000, r, e);
            chk("status", {r[13:8], r[2]}, {6'(l), wc != 0});
            apb(1'b0, 8'h10, 32'h00000000, r, e);
            chk("mr2", r, 32'((wc << 9) | (cwl << 3)));
            for (int t = 0; t <= h + l + 2; t++) begin
                cyc(t < h, 1'b1, t == 0 ? 2'd1 : 2'd0, 3'h0, {2'b00, b8[0], 12'h000});
                chk("rtt rise", {rtt_on, rtt_wr_sel, rtt_code}, exp_dyn(2 * t));
                @(negedge ck);
                chk("rtt fall", {rtt_on, rtt_wr_sel, rtt_code}, exp_dyn(2 * t + 1));
            end
        end
        // Power-down entry, DLL frozen, additive latency set
        tc = 1 + $urandom_range(3);
        tr = 1 + $urandom_range(5);
        w = tc > tr - 1 ? tc : tr - 1;
        apb(1'b1, 8'h00, {8'h00, 16'(tr), 8'(tc)}, r, e);
        for (int i = 0; i < 3; i++) cyc(1'b0, 1'b1, 2'd2, 3'(i), i == 1 ? 15'h0008 : 15'h0000);
        // Refresh two rises before CKE low may stretch the window
        cyc(1'b0, 1'b1, 2'd3, 3'h0, 15'h0000);
        cyc(1'b0, 1'b1, 2'd0, 3'h0, 15'h0000);
        cyc(1'b0, 1'b0, 2'd0, 3'h0, 15'h0000);
        for (int j = 0; j <= w + 1; j++) begin
            @(negedge ck);
            chk("pd state", {trans_window, async_mode, rtt_uncertain},
                {j < w, j >= w, 1'b1});
            cyc(1'b0, 1'b0, 2'd0, 3'h0, 15'h0000);
        end
        for (int v = 1; v >= 0; v--) begin
            i_ddt_ctrl_model.drive(v[0], 1'b0, 2'd0, 3'h0, 15'h0000);
            n = 0;
            do begin
                @(posedge pclk);
                #1;
                n++;
            end while (rtt_on !== v[0] && n < 10);
            chk("async delay", n >= 3 && n <= 4, 1);
        end
        repeat (4) cyc(1'b0, 1'b1, 2'd0, 3'h0, 15'h0000);
        chk("pd exit", 32'(async_mode), 32'h00000000);
        wrap_up();
    end
endmodule // test_ddt_core
